/* vrc_pkg.sv */
// Package with register map, field layouts and encodings of the trim and configuration register bank.
package vrc_pkg;

    // ************************************************************
    // Register command codes
    // ************************************************************
    localparam logic [7:0] VRC_CMD_TRIM_THREE_TO_FIVE_PHASE = 8'hDE;
    localparam logic [7:0] VRC_CMD_TRIM_SIX_PHASE = 8'hDF;
    localparam logic [7:0] VRC_CMD_TRIM_SPARE = 8'hE0;
    localparam logic [7:0] VRC_CMD_REGULATOR_MAIN_CONFIG = 8'hE1;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int VRC_FIVE_PHASE_LSB = 10;
    localparam int VRC_FOUR_PHASE_LSB = 5;
    localparam int VRC_THREE_PHASE_LSB = 0;
    localparam int VRC_SIX_PHASE_LSB = 0;
    localparam int VRC_TRIM_WIDTH = 5;

    // Writable bits of each register; every other bit is reserved and reads zero.
    localparam logic [15:0] VRC_TRIM_THREE_TO_FIVE_MASK = 16'h7FFF;
    localparam logic [15:0] VRC_TRIM_SIX_MASK = 16'h001F;
    localparam logic [15:0] VRC_TRIM_SPARE_MASK = 16'h0000;
    localparam logic [15:0] VRC_MAIN_CONFIG_MASK = 16'hFBF7;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] VRC_TRIM_THREE_TO_FIVE_RESET = 16'h0000;
    localparam logic [15:0] VRC_TRIM_SIX_RESET = 16'h0000;
    localparam logic [15:0] VRC_MAIN_CONFIG_RESET = 16'h40E6;

    // ************************************************************
    // Trim step size in units of 10 uV
    // ************************************************************
    localparam logic [9:0] VRC_TRIM_STEP_FULL_GAIN = 10'h0EB;
    localparam logic [9:0] VRC_TRIM_STEP_HALF_GAIN = 10'h1D6;

    // ************************************************************
    // Phase modes, also the encoding of the full-phase count field
    // ************************************************************
    typedef enum logic [2:0] {
        VRC_MODE_ONE_DCM = 3'b000,
        VRC_MODE_ONE_CCM = 3'b001,
        VRC_MODE_TWO = 3'b010,
        VRC_MODE_THREE = 3'b011,
        VRC_MODE_FOUR = 3'b100,
        VRC_MODE_FIVE = 3'b101,
        VRC_MODE_SIX = 3'b110,
        VRC_MODE_FORBIDDEN = 3'b111
    } vrc_mode_t;

    // Main configuration word, bit 15 first.
    typedef struct packed {
        logic dc_loop_enable_discontinuous;
        logic dc_loop_enable_continuous;
        logic power_state_source_select;
        logic [1:0] bus_power_state_command;
        logic reserved_10;
        logic low_state_ontime_cut_enable;
        logic power_state_command_bypass;
        logic current_balance_enable;
        logic overshoot_reduction_enable;
        logic phase_shedding_enable;
        logic vout_source_select;
        logic reserved_3;
        logic [2:0] full_phase_count;
    } vrc_config_t;

    // Controls handed to the regulation logic.
    typedef struct packed {
        logic dc_loop_enable_discontinuous;
        logic dc_loop_enable_continuous;
        logic current_balance_enable;
        logic overshoot_reduction_enable;
        logic phase_shedding_enable;
        logic vout_source_select;
        logic ontime_three_quarter;
        logic [2:0] active_phase_mode;
        logic active_trim_valid;
        logic [4:0] active_trim;
        logic [9:0] trim_step_10uv;
    } vrc_controls_t;

endpackage

/* vrc_trim_and_config_regs.sv */
// Trim and main configuration register bank of the multi-phase regulator controller.
`timescale 1ns/1ps
`default_nettype none

module vrc_trim_and_config_regs
    import vrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_write_data,
    input wire logic cmd_read,
    output logic [15:0] cmd_read_data,
    output logic cmd_read_valid,
    output logic cmd_hit,
    input wire logic remote_sense_half_gain,
    input wire logic [1:0] power_state_input,
    input wire logic [2:0] auto_phase_shedding,
    output vrc_controls_t controls
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] trim_three_to_five_phase;
        logic [15:0] trim_six_phase;
        vrc_config_t regulator_main_config;
        logic [1:0] pin_sync_first;
        logic [1:0] pin_sync_second;
        logic [1:0] pin_sync_third;
        logic [1:0] pin_code;
        logic [15:0] read_data;
        logic read_valid;
        logic hit;
        vrc_controls_t controls;
    } vrc_state_t;

    vrc_state_t state_reg;
    vrc_state_t state_next;

    logic [15:0] config_word;
    logic [1:0] state_command;
    logic [2:0] mode_from_command;
    logic [2:0] active_mode;
    logic [15:0] config_write;

    assign config_word = state_reg.regulator_main_config;

    // ************************************************************
    // Power state decode
    // ************************************************************
    function automatic logic [2:0] vrc_decode_command(input logic [1:0] command, input logic [2:0] full_count);
        logic [2:0] mode;
        mode = full_count;
        if (command[1]) begin
            mode = VRC_MODE_ONE_DCM;
        end else if (command[0]) begin
            mode = VRC_MODE_ONE_CCM;
        end
        return mode;
    endfunction

    always_comb begin
        vrc_config_t cfg;
        cfg = state_reg.regulator_main_config;
        if (cfg.power_state_source_select) begin
            state_command = cfg.bus_power_state_command;
        end else begin
            state_command = state_reg.pin_code;
        end
        mode_from_command = vrc_decode_command(state_command, cfg.full_phase_count);
        if (cfg.power_state_command_bypass) begin
            // Commands are ignored; only shedding may leave the full-phase mode.
            if (cfg.phase_shedding_enable) begin
                active_mode = auto_phase_shedding;
            end else begin
                active_mode = cfg.full_phase_count;
            end
        end else begin
            active_mode = mode_from_command;
        end
    end

    // A forbidden phase count is refused and the stored count is kept.
    always_comb begin
        config_write = cmd_write_data & VRC_MAIN_CONFIG_MASK;
        if (cmd_write_data[2:0] == VRC_MODE_FORBIDDEN) begin
            config_write[2:0] = state_reg.regulator_main_config.full_phase_count;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.pin_sync_first = power_state_input;
        state_next.pin_sync_second = state_reg.pin_sync_first;
        state_next.pin_sync_third = state_reg.pin_sync_second;
        // The two pin bits may settle on different edges, so a code is taken only once two samples agree.
        if (state_reg.pin_sync_second == state_reg.pin_sync_third) begin
            state_next.pin_code = state_reg.pin_sync_second;
        end

        // Register writes.
        if (cmd_write) begin
            case (cmd_code)
                VRC_CMD_TRIM_THREE_TO_FIVE_PHASE: begin
                    state_next.trim_three_to_five_phase = cmd_write_data & VRC_TRIM_THREE_TO_FIVE_MASK;
                end
                VRC_CMD_TRIM_SIX_PHASE: begin
                    state_next.trim_six_phase = cmd_write_data & VRC_TRIM_SIX_MASK;
                end
                VRC_CMD_REGULATOR_MAIN_CONFIG: begin
                    state_next.regulator_main_config = config_write;
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered one cycle later.
        state_next.read_valid = cmd_read;
        state_next.hit = 1'b0;
        if (cmd_read) begin
            state_next.read_data = 16'h0000;
        end
        case (cmd_code)
            VRC_CMD_TRIM_THREE_TO_FIVE_PHASE: begin
                state_next.hit = cmd_read | cmd_write;
                if (cmd_read) begin
                    state_next.read_data = state_reg.trim_three_to_five_phase & VRC_TRIM_THREE_TO_FIVE_MASK;
                end
            end
            VRC_CMD_TRIM_SIX_PHASE: begin
                state_next.hit = cmd_read | cmd_write;
                if (cmd_read) begin
                    state_next.read_data = state_reg.trim_six_phase & VRC_TRIM_SIX_MASK;
                end
            end
            VRC_CMD_TRIM_SPARE: begin
                state_next.hit = cmd_read | cmd_write;
                if (cmd_read) begin
                    state_next.read_data = VRC_TRIM_SPARE_MASK;
                end
            end
            VRC_CMD_REGULATOR_MAIN_CONFIG: begin
                state_next.hit = cmd_read | cmd_write;
                if (cmd_read) begin
                    state_next.read_data = config_word & VRC_MAIN_CONFIG_MASK;
                end
            end
            default: begin
            end
        endcase

        // Controls for the regulation logic.
        state_next.controls.dc_loop_enable_discontinuous =
            state_reg.regulator_main_config.dc_loop_enable_discontinuous;
        state_next.controls.dc_loop_enable_continuous =
            state_reg.regulator_main_config.dc_loop_enable_continuous;
        state_next.controls.current_balance_enable = state_reg.regulator_main_config.current_balance_enable;
        state_next.controls.overshoot_reduction_enable =
            state_reg.regulator_main_config.overshoot_reduction_enable;
        state_next.controls.phase_shedding_enable = state_reg.regulator_main_config.phase_shedding_enable;
        state_next.controls.vout_source_select = state_reg.regulator_main_config.vout_source_select;
        state_next.controls.ontime_three_quarter = state_reg.regulator_main_config.low_state_ontime_cut_enable
            && (active_mode == VRC_MODE_ONE_DCM);
        state_next.controls.active_phase_mode = active_mode;
        if (remote_sense_half_gain) begin
            state_next.controls.trim_step_10uv = VRC_TRIM_STEP_HALF_GAIN;
        end else begin
            state_next.controls.trim_step_10uv = VRC_TRIM_STEP_FULL_GAIN;
        end

        // Modes below three phases take their trims from elsewhere.
        state_next.controls.active_trim_valid = 1'b1;
        case (active_mode)
            VRC_MODE_THREE: begin
                state_next.controls.active_trim =
                    state_reg.trim_three_to_five_phase[VRC_THREE_PHASE_LSB +: VRC_TRIM_WIDTH];
            end
            VRC_MODE_FOUR: begin
                state_next.controls.active_trim =
                    state_reg.trim_three_to_five_phase[VRC_FOUR_PHASE_LSB +: VRC_TRIM_WIDTH];
            end
            VRC_MODE_FIVE: begin
                state_next.controls.active_trim =
                    state_reg.trim_three_to_five_phase[VRC_FIVE_PHASE_LSB +: VRC_TRIM_WIDTH];
            end
            VRC_MODE_SIX: begin
                state_next.controls.active_trim =
                    state_reg.trim_six_phase[VRC_SIX_PHASE_LSB +: VRC_TRIM_WIDTH];
            end
            default: begin
                state_next.controls.active_trim = 5'h00;
                state_next.controls.active_trim_valid = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.trim_three_to_five_phase <= VRC_TRIM_THREE_TO_FIVE_RESET;
            state_reg.trim_six_phase <= VRC_TRIM_SIX_RESET;
            state_reg.regulator_main_config <= VRC_MAIN_CONFIG_RESET;
            state_reg.controls.trim_step_10uv <= VRC_TRIM_STEP_FULL_GAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cmd_read_data = state_reg.read_data;
    assign cmd_read_valid = state_reg.read_valid;
    assign cmd_hit = state_reg.hit;
    assign controls = state_reg.controls;

endmodule

`default_nettype wire

/* vrc_regs_chk.sv */
// Property checker of the trim and configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module vrc_regs_chk
    import vrc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_write_data,
    input wire logic cmd_read,
    input wire logic [15:0] cmd_read_data,
    input wire logic cmd_read_valid,
    input wire logic cmd_hit,
    input wire logic remote_sense_half_gain,
    input wire vrc_controls_t controls
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire logic mapped = cmd_code inside {8'hDE, 8'hDF, 8'hE0, 8'hE1};
    wire logic [2:0] mode = controls.active_phase_mode;
    AST_ANSWER: assert property (cmd_read |=> cmd_read_valid && cmd_hit == $past(mapped)) else $error("bad answer");
    AST_SPARE: assert property (cmd_read && cmd_code == 8'hE0 |=> cmd_read_data == 16'h0000)
        else $error("spare not zero");
    AST_SIX: assert property (cmd_read && cmd_code == 8'hDF |=> cmd_read_data[15:5] == 11'h000)
        else $error("six-phase upper bits set");
    AST_TOP: assert property (cmd_read && cmd_code == 8'hDE |=> !cmd_read_data[15]) else $error("bit 15 set");
    AST_CFG: assert property (cmd_read && cmd_code == 8'hE1 |=> cmd_read_data[10] == 1'b0 && !cmd_read_data[3])
        else $error("config fixed bits set");
    AST_STEP_HALF: assert property (remote_sense_half_gain ##1 remote_sense_half_gain |->
        controls.trim_step_10uv == 10'h1D6) else $error("half gain step wrong");
    AST_STEP_FULL: assert property (!remote_sense_half_gain ##1 !remote_sense_half_gain |->
        controls.trim_step_10uv == 10'h0EB) else $error("full gain step wrong");
    AST_ONTIME: assert property (controls.ontime_three_quarter |-> mode == 3'h0) else $error("on-time cut");
    AST_VALID: assert property (controls.active_trim_valid == (mode inside {[3'h3:3'h6]}))
        else $error("trim valid wrong");
    AST_BALANCE: assert property (cmd_write && cmd_code == 8'hE1 |-> ##2
        controls.current_balance_enable == $past(cmd_write_data[7], 2)) else $error("balance copy wrong");
    AST_DC_LOOP: assert property (cmd_write && cmd_code == 8'hE1 |-> ##2
        controls.dc_loop_enable_discontinuous == $past(cmd_write_data[15], 2)) else $error("dc copy wrong");
    COV_CFG: cover property (cmd_write && cmd_code == 8'hE1);
    COV_ONTIME: cover property (controls.ontime_three_quarter);
    COV_MISS: cover property (cmd_read && !mapped);
endmodule
bind vrc_trim_and_config_regs vrc_regs_chk chk_u (.clk(clk), .reset_n(reset_n), .cmd_code(cmd_code),
    .cmd_write(cmd_write), .cmd_write_data(cmd_write_data), .cmd_read(cmd_read), .cmd_read_data(cmd_read_data),
    .cmd_read_valid(cmd_read_valid), .cmd_hit(cmd_hit), .remote_sense_half_gain(remote_sense_half_gain),
    .controls(controls));
`default_nettype wire

/* vrc_host_model.sv */
// Host model that drives register reads and writes on the command port.
`timescale 1ns/1ps
`default_nettype none
module vrc_host_model (
    input wire logic clk,
    output logic [7:0] cmd_code,
    output logic cmd_write,
    output logic [15:0] cmd_write_data,
    output logic cmd_read,
    input wire logic [15:0] cmd_read_data,
    input wire logic cmd_hit
);
    initial begin
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_write_data = 16'h0000;
        cmd_read = 1'b0;
    end
    // Write data is inverted once the strobe drops so that stale data is never mistaken for valid.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmd_code = c;
        cmd_write_data = d;
        cmd_write = 1'b1;
        @(negedge clk);
        cmd_write = 1'b0;
        cmd_write_data = ~d;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic h);
        @(negedge clk);
        cmd_code = c;
        cmd_read = 1'b1;
        @(negedge clk);
        cmd_read = 1'b0;
        d = cmd_read_data;
        h = cmd_hit;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench of the trim and configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import vrc_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic gain = 1'b0;
    logic [1:0] pin = 2'h0;
    logic [7:0] code;
    logic wr_en, rd_en, hit, seen_hit, rvalid;
    logic [2:0] shed = 3'h4;
    logic [15:0] wdata, rdata, seen;
    vrc_controls_t ctl;
    int fails = 0;
    int compares = 0;
    localparam logic [15:0] WORDS [11] = '{16'h2003, 16'h2004, 16'h2005, 16'h2006, 16'h2806, 16'h3206,
        16'h3806, 16'h0206, 16'h0206, 16'h0126, 16'h0106};
    localparam logic [1:0] PINS [11] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
    localparam logic [2:0] MODES [11] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h0, 3'h0, 3'h1, 3'h0, 3'h4, 3'h6};
    localparam logic [15:0] CFGS [2] = '{16'h80A6, 16'h4056};
    always #2.5 clk = ~clk;
    vrc_host_model host_u (.clk(clk), .cmd_code(code), .cmd_write(wr_en), .cmd_write_data(wdata),
        .cmd_read(rd_en), .cmd_read_data(rdata), .cmd_hit(hit));
    vrc_trim_and_config_regs dut_u (.clk(clk), .reset_n(reset_n), .cmd_code(code), .cmd_write(wr_en),
        .cmd_write_data(wdata), .cmd_read(rd_en), .cmd_read_data(rdata), .cmd_read_valid(rvalid), .cmd_hit(hit),
        .remote_sense_half_gain(gain), .power_state_input(pin), .auto_phase_shedding(shed), .controls(ctl));
    function automatic logic [4:0] trim_of(input logic [2:0] m);
        case (m)
            3'h3: return 5'h03;
            3'h4: return 5'h0A;
            3'h5: return 5'h15;
            3'h6: return 5'h1C;
            default: return 5'h00;
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
        host_u.rd(c, seen, seen_hit);
        check("read", seen, exp);
        check("valid", {15'h0000, rvalid}, 16'h0001);
        check("hit", {15'h0000, seen_hit}, {15'h0000, c inside {8'hDE, 8'hDF, 8'hE0, 8'hE1}});
    endtask
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        rchk(8'hDE, VRC_TRIM_THREE_TO_FIVE_RESET);
        rchk(8'hDF, VRC_TRIM_SIX_RESET);
        rchk(8'hE1, VRC_MAIN_CONFIG_RESET);
        host_u.wr(8'hDE, 16'hD543);
        rchk(8'hDE, 16'h5543);
        host_u.wr(8'hDF, 16'hFFFC);
        rchk(8'hDF, 16'h001C);
        host_u.wr(8'hE0, 16'hFFFF);
        rchk(8'hE0, 16'h0000);
        host_u.wr(8'hE1, 16'hFFFF);
        rchk(8'hE1, 16'hFBF6);
        host_u.wr(8'h55, 16'hFFFF);
        rchk(8'h55, 16'h0000);
        for (int i = 0; i < 11; i++) begin
            host_u.wr(8'hE1, WORDS[i]);
            pin = PINS[i];
            repeat (5) @(negedge clk);
            check("mode", {13'h0000, ctl.active_phase_mode}, {13'h0000, MODES[i]});
            check("trim", {10'h000, ctl.active_trim_valid, ctl.active_trim},
                {10'h000, MODES[i] inside {[3'h3:3'h6]}, trim_of(MODES[i])});
            check("ontime", {15'h0000, ctl.ontime_three_quarter}, {15'h0000, WORDS[i][9] && MODES[i] == 3'h0});
        end
        host_u.wr(8'hE1, 16'h0126);
        shed = 3'h2;
        repeat (2) @(negedge clk);
        check("shed", {13'h0000, ctl.active_phase_mode}, 16'h0002);
        check("shed trim", {15'h0000, ctl.active_trim_valid}, 16'h0000);
        foreach (CFGS[j]) begin
            host_u.wr(8'hE1, CFGS[j]);
            repeat (2) @(negedge clk);
            check("enables", {10'h000, ctl.dc_loop_enable_discontinuous,
                ctl.dc_loop_enable_continuous, ctl.current_balance_enable, ctl.overshoot_reduction_enable,
                ctl.phase_shedding_enable, ctl.vout_source_select}, {10'h000, CFGS[j][15:14], CFGS[j][7:4]});
        end
        gain = 1'b1;
        repeat (2) @(negedge clk);
        check("step", {6'h00, ctl.trim_step_10uv}, 16'h01D6);
        gain = 1'b0;
        repeat (2) @(negedge clk);
        check("step", {6'h00, ctl.trim_step_10uv}, 16'h00EB);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rchk(8'hDE, VRC_TRIM_THREE_TO_FIVE_RESET);
        rchk(8'hE1, VRC_MAIN_CONFIG_RESET);
        summarize();
    end
endmodule
`default_nettype wire
